// *** design/dsb_defines.svh ***
// constants for the decrement, skip and jump execution block
`ifndef DSB_DEFINES_SVH
`define DSB_DEFINES_SVH

`define DSB_WORD_W        14
`define DSB_PC_W          13
`define DSB_DATA_W        8
`define DSB_FADDR_W       7
`define DSB_JUMP_K_W      11
`define DSB_LATCH_W       8

`define DSB_OPC_HI        13
`define DSB_OPC_LO        8
`define DSB_JMP_OPC_LO    11
`define DSB_DEST_BIT      7
`define DSB_FADDR_HI      6
`define DSB_K_HI          10
`define DSB_LATCH_HI      4
`define DSB_LATCH_LO      3

`define DSB_OPC_DEC_FILE  6'h03
`define DSB_OPC_DEC_SKIP  6'h0b
`define DSB_OPC_JUMP      3'h5

`define DSB_NOP_WORD      14'h0000
`define DSB_PC_RESET      13'h0000
`define DSB_PC_STEP       13'h0001
`define DSB_DATA_ONE      8'h01
`define DSB_DATA_ZERO     8'h00
`define DSB_FADDR_RESET   7'h00

`endif

// *** design/dsb_pkg.sv ***
// types for the decrement, skip and jump execution block
`include "dsb_defines.svh"

package dsb_pkg;

  typedef enum logic [1:0] {
    ph_q1 = 2'b00,
    ph_q2 = 2'b01,
    ph_q3 = 2'b10,
    ph_q4 = 2'b11
  } dsb_phase_t;

  typedef enum logic [1:0] {
    op_other     = 2'b00,
    op_dec_file  = 2'b01,
    op_dec_skip  = 2'b10,
    op_jump      = 2'b11
  } dsb_op_t;

  typedef struct packed {
    dsb_phase_t                   phase;
    logic [`DSB_PC_W-1:0]         pc;
    logic [`DSB_WORD_W-1:0]       exec_word;
    logic                         nop_slot;
    logic [`DSB_FADDR_W-1:0]      file_addr;
    logic [`DSB_DATA_W-1:0]       operand;
    logic                         file_wr_en;
    logic [`DSB_DATA_W-1:0]       file_wr_data;
    logic [`DSB_DATA_W-1:0]       w;
    logic                         z;
    logic                         flush;
    logic                         foreign_op;
  } dsb_state_t;

endpackage

// *** design/dsb_decode.sv ***
// instruction word decoder for the three handled instructions
`timescale 1ns/1ps
`default_nettype none
`include "dsb_defines.svh"

module dsb_decode (
  input  wire logic [`DSB_WORD_W-1:0]   word,     // executing instruction word
  output dsb_pkg::dsb_op_t              op,       // decoded instruction kind
  output logic                          dest,     // 1: file register, 0: working register
  output logic [`DSB_FADDR_W-1:0]       faddr,    // file register address
  output logic [`DSB_JUMP_K_W-1:0]      jump_k    // jump immediate
);

  always_comb begin
    dest   = word[`DSB_DEST_BIT];
    faddr  = word[`DSB_FADDR_HI:0];
    jump_k = word[`DSB_K_HI:0];
    if (word[`DSB_OPC_HI:`DSB_OPC_LO] == `DSB_OPC_DEC_FILE) begin             // [RULE1]
      op = dsb_pkg::op_dec_file;
    end else if (word[`DSB_OPC_HI:`DSB_OPC_LO] == `DSB_OPC_DEC_SKIP) begin    // [RULE3]
      op = dsb_pkg::op_dec_skip;
    end else if (word[`DSB_OPC_HI:`DSB_JMP_OPC_LO] == `DSB_OPC_JUMP) begin    // [RULE8]
      op = dsb_pkg::op_jump;
    end else begin
      op = dsb_pkg::op_other;
    end
  end

endmodule

`default_nettype wire

// *** design/dsb_alu.sv ***
// decrement unit with zero detect
`timescale 1ns/1ps
`default_nettype none
`include "dsb_defines.svh"

module dsb_alu (
  input  wire logic [`DSB_DATA_W-1:0]   operand,  // file register value
  output logic [`DSB_DATA_W-1:0]        result,   // operand minus one
  output logic                          is_zero   // result equals zero
);

  always_comb begin
    result  = operand - `DSB_DATA_ONE;                                       // [RULE1] [RULE3]
    is_zero = (result == `DSB_DATA_ZERO);
  end

endmodule

`default_nettype wire

// *** design/dsb_exec.sv ***
// execution core slice for decrement, decrement-skip and unconditional jump
// Operation
// RULE1 - decode decrement-file from 00 0011, bit 7 destination, bits 6:0 address; subtract one
// RULE2 - decrement-file result goes to working register if dest 0, file if 1
// RULE3 - decode decrement-skip from 00 1011, same fields; subtract one from addressed value
// RULE4 - decrement-skip result goes to working register if dest 0, file if 1
// RULE5 - decrement-skip skips the next instruction when its result is zero
// RULE6 - a taken skip discards the already fetched word unexecuted
// RULE7 - a taken skip runs a no-operation cycle instead, two cycles total
// RULE8 - jump decoded from 10 1, eleven-bit immediate loads program counter 10:0
// RULE9 - jump copies high latch bits 4:3 into program counter 12:11
// RULE10 - jump takes two instruction cycles, flushing the sequentially fetched word
// RULE11 - decrement-file updates zero flag; skip and jump leave status unchanged
`timescale 1ns/1ps
`default_nettype none
`include "dsb_defines.svh"

module dsb_exec (
  input  wire logic                       clk,           // 20 MHz core clock
  input  wire logic                       rst_b,         // async reset, active low
  input  wire logic [`DSB_WORD_W-1:0]     prog_data,     // word read at prog_addr
  input  wire logic [`DSB_DATA_W-1:0]     file_rd_data,  // file register at file_addr
  input  wire logic [`DSB_LATCH_W-1:0]    pc_high_latch, // program counter high latch
  output logic [`DSB_PC_W-1:0]            prog_addr,     // fetch address
  output logic [`DSB_FADDR_W-1:0]         file_addr,     // file register address
  output logic                            file_wr_en,    // file write strobe
  output logic [`DSB_DATA_W-1:0]          file_wr_data,  // file write data
  output logic [`DSB_DATA_W-1:0]          w_reg,         // working register
  output logic                            z_flag,        // zero flag
  output logic                            nop_slot,      // current cycle is a forced no-op
  output logic                            foreign_op,    // current word handled elsewhere
  output logic [1:0]                      phase          // instruction cycle quarter
);

  ////////////////////////////////////////////////////////////////////////////////
  // state and decode of the executing word

  dsb_pkg::dsb_state_t              s_r;
  dsb_pkg::dsb_state_t              s_nxt;
  dsb_pkg::dsb_op_t                 dec_op;
  logic                             dec_dest;
  logic [`DSB_FADDR_W-1:0]          dec_faddr;
  logic [`DSB_JUMP_K_W-1:0]         dec_k;
  logic [`DSB_DATA_W-1:0]           alu_result;
  logic                             alu_zero;
  logic                             is_dec;

  dsb_decode u_decode (
    .word   (s_r.exec_word),
    .op     (dec_op),
    .dest   (dec_dest),
    .faddr  (dec_faddr),
    .jump_k (dec_k)
  );

  dsb_alu u_alu (
    .operand (s_r.operand),
    .result  (alu_result),
    .is_zero (alu_zero)
  );

  // a forced no-op holds the all-zero word, which never decodes as a handled op
  assign is_dec = (dec_op == dsb_pkg::op_dec_file) || (dec_op == dsb_pkg::op_dec_skip);

  ////////////////////////////////////////////////////////////////////////////////
  // four quarters make one instruction cycle: the quarter counter is the divider

  always_comb begin
    s_nxt            = s_r;
    s_nxt.file_wr_en = 1'b0;
    unique case (s_r.phase)
      dsb_pkg::ph_q1: begin
        s_nxt.phase      = dsb_pkg::ph_q2;
        s_nxt.file_addr  = dec_faddr;                                        // [RULE1] [RULE3]
        s_nxt.foreign_op = (dec_op == dsb_pkg::op_other) && !s_r.nop_slot;
        s_nxt.flush      = 1'b0;
      end
      dsb_pkg::ph_q2: begin
        s_nxt.phase   = dsb_pkg::ph_q3;
        s_nxt.operand = file_rd_data;
      end
      dsb_pkg::ph_q3: begin
        s_nxt.phase = dsb_pkg::ph_q4;
        if (is_dec) begin
          if (dec_dest) begin                                               // [RULE2] [RULE4]
            s_nxt.file_wr_en   = 1'b1;
            s_nxt.file_wr_data = alu_result;
          end else begin
            s_nxt.w = alu_result;                                            // [RULE2] [RULE4]
          end
        end
        // only the plain decrement touches status; skip and jump leave it alone
        if (dec_op == dsb_pkg::op_dec_file) begin
          s_nxt.z = alu_zero;                                                // [RULE11]
        end
        s_nxt.flush = ((dec_op == dsb_pkg::op_dec_skip) && alu_zero)         // [RULE5]
                    || (dec_op == dsb_pkg::op_jump);                         // [RULE10]
      end
      dsb_pkg::ph_q4: begin
        s_nxt.phase = dsb_pkg::ph_q1;
        if (dec_op == dsb_pkg::op_jump) begin
          s_nxt.pc = {pc_high_latch[`DSB_LATCH_HI:`DSB_LATCH_LO], dec_k};    // [RULE8] [RULE9]
        end else begin
          s_nxt.pc = s_r.pc + `DSB_PC_STEP;
        end
        // the word fetched during this cycle is dropped when a skip or jump was taken;
        // its slot runs as a no-op so the taking instruction spans two cycles
        if (s_r.flush) begin
          s_nxt.exec_word = `DSB_NOP_WORD;                                   // [RULE6] [RULE10]
          s_nxt.nop_slot  = 1'b1;                                            // [RULE7]
        end else begin
          s_nxt.exec_word = prog_data;
          s_nxt.nop_slot  = 1'b0;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_r.phase        <= dsb_pkg::ph_q1;
      s_r.pc           <= `DSB_PC_RESET;
      s_r.exec_word    <= `DSB_NOP_WORD;
      s_r.nop_slot     <= 1'b1;
      s_r.file_addr    <= `DSB_FADDR_RESET;
      s_r.operand      <= `DSB_DATA_ZERO;
      s_r.file_wr_en   <= 1'b0;
      s_r.file_wr_data <= `DSB_DATA_ZERO;
      s_r.w            <= `DSB_DATA_ZERO;
      s_r.z            <= 1'b0;
      s_r.flush        <= 1'b0;
      s_r.foreign_op   <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register

  assign prog_addr    = s_r.pc;
  assign file_addr    = s_r.file_addr;
  assign file_wr_en   = s_r.file_wr_en;
  assign file_wr_data = s_r.file_wr_data;
  assign w_reg        = s_r.w;
  assign z_flag       = s_r.z;
  assign nop_slot     = s_r.nop_slot;
  assign foreign_op   = s_r.foreign_op;
  assign phase        = s_r.phase;

endmodule

`default_nettype wire

// *** bench/dsb_exec_props.sv ***
// concurrent checks on the ports of the execution slice
`timescale 1ns/1ps
`default_nettype none
`include "dsb_defines.svh"

module dsb_exec_props (
  input wire logic        clk,           // clock
  input wire logic        rst_b,         // reset
  input wire logic [13:0] prog_data,     // fetch word
  input wire logic [7:0]  file_rd_data,  // operand
  input wire logic [7:0]  pc_high_latch, // high latch
  input wire logic [12:0] prog_addr,     // fetch address
  input wire logic [6:0]  file_addr,     // file address
  input wire logic        file_wr_en,    // write strobe
  input wire logic [7:0]  file_wr_data,  // write data
  input wire logic [7:0]  w_reg,         // working reg
  input wire logic        z_flag,        // zero flag
  input wire logic        nop_slot,      // forced no-op
  input wire logic        foreign_op,    // other word
  input wire logic [1:0]  phase          // quarter
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  ////////////////////////////////////////////////////////////////////////////////
  a_wr_one_clk: assert property (file_wr_en |-> phase == 2'h3 ##1 !file_wr_en)
    else $error("write strobe not a single Q4 clock");
  a_wr_data_dec: assert property (
      file_wr_en |-> file_wr_data == $past(file_rd_data, 2) - 8'h01)
    else $error("written value is not operand minus one");
  a_z_from_file: assert property (
      $changed(z_flag) |-> phase == 2'h3 && z_flag == ($past(file_rd_data, 2) == 8'h01))
    else $error("zero flag change does not match result");
  a_jump_flush: assert property (
      $changed(prog_addr) && prog_addr != $past(prog_addr) + 13'h1 |-> nop_slot)
    else $error("jump without a no-op slot");
  a_nop_quiet: assert property (nop_slot |-> !file_wr_en && !foreign_op)
    else $error("discarded word had an effect");
  a_nop_keeps_w: assert property (
      nop_slot && phase == 2'h3 |-> $stable(w_reg) && $stable(z_flag))
    else $error("no-op cycle changed working register or flag");
  a_nop_pc_step: assert property (
      nop_slot && phase == 2'h3 |=> prog_addr == $past(prog_addr) + 13'h1)
    else $error("no-op cycle did not advance the fetch address");
  a_pc_q4_only: assert property (phase != 2'h3 |=> $stable(prog_addr))
    else $error("fetch address moved outside Q4");
  c_zero_write: cover property (file_wr_en && file_wr_data == 8'h00);
  c_nop_cycle: cover property (nop_slot && phase == 2'h1 && $past(prog_addr) != 13'h0000);
  c_z_change: cover property ($changed(z_flag));
endmodule

bind dsb_exec dsb_exec_props u_props (
  .clk           (clk),
  .rst_b         (rst_b),
  .prog_data     (prog_data),
  .file_rd_data  (file_rd_data),
  .pc_high_latch (pc_high_latch),
  .prog_addr     (prog_addr),
  .file_addr     (file_addr),
  .file_wr_en    (file_wr_en),
  .file_wr_data  (file_wr_data),
  .w_reg         (w_reg),
  .z_flag        (z_flag),
  .nop_slot      (nop_slot),
  .foreign_op    (foreign_op),
  .phase         (phase)
);
`default_nettype wire

// *** bench/tb_decrement_skip_branch_exec.sv ***
// self-checking bench for the decrement, skip and jump slice
`timescale 1ns/1ps
`default_nettype none

module tb_decrement_skip_branch_exec;
  logic        clk, rst_b, file_wr_en, z_flag, nop_slot, foreign_op;
  logic [13:0] prog_data;
  logic [7:0]  file_rd_data, pc_high_latch, file_wr_data, w_reg;
  logic [12:0] prog_addr;
  logic [6:0]  file_addr;
  logic [1:0]  phase;
  int          error_cnt = 0;
  int          tests_run = 0;
  int          cyc = 0;

  dsb_exec uut (
    .clk           (clk),
    .rst_b         (rst_b),
    .prog_data     (prog_data),
    .file_rd_data  (file_rd_data),
    .pc_high_latch (pc_high_latch),
    .prog_addr     (prog_addr),
    .file_addr     (file_addr),
    .file_wr_en    (file_wr_en),
    .file_wr_data  (file_wr_data),
    .w_reg         (w_reg),
    .z_flag        (z_flag),
    .nop_slot      (nop_slot),
    .foreign_op    (foreign_op),
    .phase         (phase)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [12:0] exp, input logic [12:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  function automatic logic [12:0] jump_pc(input logic [7:0] lat, input logic [13:0] wd);
    return {lat[4:3], wd[10:0]};
  endfunction

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // 200 instruction cycles take about 810 clocks
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      error_cnt++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // the bench acts as program memory but ignores prog_addr, so the model tracks it
  initial begin
    logic [13:0] exe, nw, r;
    logic [7:0]  fv, res, ew, lat;
    logic [12:0] pc;
    logic        ez, fl, dfo, dsk, jmp;
    prog_data = 14'h0000;
    file_rd_data = 8'h00;
    pc_high_latch = 8'h00;
    rst_b = 1'b0;
    void'($urandom(32'h27ae));
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    pc = 13'h0000;
    ew = 8'h00;
    ez = 1'b0;
    fl = 1'b1;
    exe = 14'h0000;
    for (int i = 0; i < 200; i++) begin
      r = 14'($urandom);
      case ($urandom_range(3))
        0: nw = {6'h03, r[7:0]};
        1: nw = {6'h0b, r[7:0]};
        2: nw = {3'h5, r[10:0]};
        default: nw = r;
      endcase
      // bias towards one so the zero result and skip are hit often
      fv = ($urandom_range(2) == 0) ? 8'h01 : 8'($urandom);
      if (i < 8) fv = 8'(i % 3);
      lat = 8'($urandom);
      prog_data = nw;
      file_rd_data = fv;
      pc_high_latch = lat;
      res = fv - 8'h01;
      dfo = !fl && exe[13:8] == 6'h03;
      dsk = !fl && exe[13:8] == 6'h0b;
      jmp = !fl && exe[13:11] == 3'h5;
      if ((dfo || dsk) && !exe[7]) ew = res;
      if (dfo) ez = (res == 8'h00);
      repeat (3) @(negedge clk);
      chk("file_wr_en", 13'((dfo || dsk) && exe[7]), 13'(file_wr_en));
      chk("phase", 13'h3, 13'(phase));
      if ((dfo || dsk) && exe[7]) begin
        chk("file_wr_data", 13'(res), 13'(file_wr_data));
      end
      if (dfo || dsk) chk("file_addr", 13'(exe[6:0]), 13'(file_addr));
      chk("w_reg", 13'(ew), 13'(w_reg));
      chk("z_flag", 13'(ez), 13'(z_flag));
      chk("foreign_op", 13'(!fl && !dfo && !dsk && !jmp), 13'(foreign_op));
      @(negedge clk);
      pc = jmp ? jump_pc(lat, exe) : pc + 13'h1;
      fl = jmp || (dsk && res == 8'h00);
      chk("prog_addr", pc, prog_addr);
      chk("nop_slot", 13'(fl), 13'(nop_slot));
      exe = nw;
      $display("cycle %0d done", i);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
